// ### rci_pkg.sv
// rci_pkg: shared constants and types for the reset-cause and init block
// assumes: 32-bit axi4-lite register bus, 8-bit core registers in low bits
package rci_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PC_W   = 13;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [7:0] IDX_CORE_STATUS = 8'h03;
  localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0c;
  localparam logic [7:0] IDX_OPTION_CTRL = 8'h81;
  localparam logic [7:0] IDX_PORT_B_DIR  = 8'h86;
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] IDX_CONFIG_WORD = 8'h90;

  // ----------------------------------------------------------------------
  // field positions, masks and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned ST_TIMEOUT_BIT  = 4;
  localparam int unsigned ST_PWRDOWN_BIT  = 3;
  localparam logic [7:0]  STATUS_RST      = 8'h18;
  localparam logic [7:0]  STATUS_SW_MASK  = 8'he7;
  localparam int unsigned CAUSE_POR_BIT   = 1;
  localparam int unsigned CAUSE_BOR_BIT   = 0;
  localparam logic [7:0]  CAUSE_MASK      = 8'h03;
  localparam logic [7:0]  CAUSE_RST       = 8'h00;
  localparam logic [7:0]  OPTION_RST      = 8'hff;
  localparam logic [7:0]  PORT_B_DIR_RST  = 8'hff;
  localparam int unsigned OPT_ASSIGN_BIT  = 3;
  localparam int unsigned OPT_RATIO_LSB   = 0;
  localparam int unsigned PIR_CMP_BIT     = 6;
  localparam logic [7:0]  PIR_MASK        = 8'h40;
  localparam logic [7:0]  PIR_RST         = 8'h00;
  localparam int unsigned CFG_OSC_LSB     = 0;
  localparam int unsigned CFG_BOD_EN_BIT  = 6;
  localparam logic [7:0]  CFG_MASK        = 8'h43;
  localparam logic [7:0]  CFG_RST         = 8'h43;
  localparam logic [12:0] PC_RESET_ADDR   = 13'h000;
  localparam logic [12:0] PC_INT_VECTOR   = 13'h004;
  localparam int unsigned WDT_LIMIT_DFLT  = 256;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    low_power_crystal_mode,
    crystal_resonator_mode,
    high_speed_crystal_mode,
    resistor_capacitor_mode
  } rci_osc_mode_t;

  typedef enum logic [2:0] {
    cond_none,
    cond_brown_out,
    cond_ext_run,
    cond_ext_sleep,
    cond_wdt_reset,
    cond_wdt_wake,
    cond_int_wake
  } rci_cond_t;

  typedef enum logic [0:0] {
    pc_idle,
    pc_vector
  } rci_pc_state_t;

  // register index from a byte address
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] addr);
    idx_of = addr[9:2];
  endfunction : idx_of

endpackage : rci_pkg

// ### rci_prescaler.sv
// rci_prescaler: shared 8-bit divider for timer or watchdog
// assumes: source ticks are one-cycle pulses on aclk
`timescale 1ns/1ps
module rci_prescaler
  import rci_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // control
  input  wire logic       assign_wdt,
  input  wire logic [2:0] ratio,
  input  wire logic       clear,
  // tick sources and outputs
  input  wire logic       timer_src,
  input  wire logic       wdt_src,
  output logic            timer_inc,
  output logic            wdt_step
);

  // ----------------------------------------------------------------------
  // divider decode
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic             assign_q;
  wire              src   = assign_wdt ? wdt_src : timer_src;
  wire  [3:0]       shift = assign_wdt ? {1'b0, ratio} : {1'b0, ratio} + 4'h1;
  wire  [8:0]       wide  = (9'h001 << shift) - 9'h001;
  wire  [CNT_W-1:0] mask  = wide[CNT_W-1:0];
  wire              swap  = assign_wdt != assign_q;
  wire              tap   = src && ((cnt_q & mask) == mask) && !swap;

  // only one consumer is divided, the other passes straight through
  assign timer_inc = assign_wdt ? (timer_src && !swap) : tap;
  assign wdt_step  = assign_wdt ? tap : (wdt_src && !swap);

  // ----------------------------------------------------------------------
  // counter, hidden from software
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= '0;
      assign_q <= 1'b1;
    end else if (ce) begin
      assign_q <= assign_wdt;
      if (clear || swap) begin
        cnt_q <= '0;
      end else if (src) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : rci_prescaler

// ### rci_top.sv
// rci_top: reset-cause recording, init values, prescaler and watchdog
// assumes: aresetn low is the power-on reset; events are one-cycle pulses
//
// What this block does
// - power-on reset clears power-on flag
// - brown-out reset clears brown-out flag
// - cause bits 7-2 read zero, ignore writes
// - brown-out flag don't-care when detector off
// - one divider, timer or watchdog only
// - option low nibble selects owner, ratio
// - timer count write clears divider when timer owns it
// - watchdog clear clears watchdog, and divider when watchdog owns it
// - divider count has no software address
// - two config bits pick oscillator mode
// - crystal modes accept external clock input
// - resets load pc zero, wakes pc+1
// - interrupt wake with enable then vectors 0004h
// - status upper bits load per reset cause
// - interrupt wake and running pin reset status
// - cause register values per reset type
// - resets set option and port b dir
// - comparator wake sets peripheral flag bit 6
// - watchdog time-out clears time-out flag
// - watchdog divide ratios up to 1:128
// - clear and sleep clear watchdog, divider if watchdog owns it
`timescale 1ns/1ps
module rci_top
  import rci_pkg::*;
#(
  parameter int unsigned WDT_W     = 16,
  parameter int unsigned WDT_LIMIT = WDT_LIMIT_DFLT,
  parameter logic [7:0]  CFG_INIT  = CFG_RST
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // core events
  input  wire logic              brown_out_evt,
  input  wire logic              ext_reset_evt,
  input  wire logic              int_wake_evt,
  input  wire logic              cmp_wake_evt,
  input  wire logic              global_interrupt_enable,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              sleep_instr,
  input  wire logic [PC_W-1:0]   pc_current,
  // tick sources
  input  wire logic              timer_tick,
  input  wire logic              wdt_osc_tick,
  // core outputs
  output logic                   core_reset,
  output logic                   pc_load,
  output logic [PC_W-1:0]        pc_value,
  output logic                   sleeping,
  output logic [7:0]             option_value,
  output logic [7:0]             port_b_direction,
  output logic [1:0]             osc_mode,
  output logic                   ext_clock_ok
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                aw_hold_q, w_hold_q, wstrb0_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [7:0]          wdata_q;
  logic [7:0]          status_q, cause_q, option_q, port_b_direction_q, pir_q, cfg_q;
  logic [7:0]          timer_count_q;
  logic [WDT_W-1:0]    wdt_cnt_q;
  logic                sleep_q, core_reset_q, pc_load_q;
  logic [PC_W-1:0]     pc_value_q;
  rci_osc_mode_t       osc_mode_q;
  logic                ext_clock_ok_q;
  rci_pc_state_t       pc_state_q;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire        aw_take   = awvalid && awready_q;
  wire        w_take    = wvalid && wready_q;
  wire        ar_take   = arvalid && arready_q;
  wire        do_write  = aw_hold_q && w_hold_q && !bvalid_q;
  wire  [7:0] wr_idx    = idx_of(awaddr_q);
  wire  [7:0] rd_idx    = idx_of(araddr);
  wire        wr_en     = do_write && wstrb0_q;
  wire        wr_timer  = wr_en && (wr_idx == IDX_TIMER_COUNT);
  wire        wr_status = wr_en && (wr_idx == IDX_CORE_STATUS);
  wire        wr_pir    = wr_en && (wr_idx == IDX_PERIPH_FLAG);
  wire        wr_option = wr_en && (wr_idx == IDX_OPTION_CTRL);
  wire        wr_port_b_direction  = wr_en && (wr_idx == IDX_PORT_B_DIR);
  wire        wr_cause  = wr_en && (wr_idx == IDX_RESET_CAUSE);
  wire        wr_cfg    = wr_en && (wr_idx == IDX_CONFIG_WORD);

  // mapped check, the divider count has no index of its own
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IDX_TIMER_COUNT) || (idx == IDX_CORE_STATUS) ||
                (idx == IDX_PERIPH_FLAG) || (idx == IDX_OPTION_CTRL) ||
                (idx == IDX_PORT_B_DIR)  || (idx == IDX_RESET_CAUSE) ||
                (idx == IDX_CONFIG_WORD);
  endfunction : is_mapped

  // read mux, narrow registers in the low byte
  wire  [7:0] rd_byte =
      (rd_idx == IDX_TIMER_COUNT) ? timer_count_q :
      (rd_idx == IDX_CORE_STATUS) ? status_q :
      (rd_idx == IDX_PERIPH_FLAG) ? pir_q :
      (rd_idx == IDX_OPTION_CTRL) ? option_q :
      (rd_idx == IDX_PORT_B_DIR)  ? port_b_direction_q :
      (rd_idx == IDX_RESET_CAUSE) ? (cause_q & CAUSE_MASK) :
      (rd_idx == IDX_CONFIG_WORD) ? cfg_q : 8'h00;

  // ----------------------------------------------------------------------
  // prescaler and watchdog
  // ----------------------------------------------------------------------
  wire       assign_wdt = option_q[OPT_ASSIGN_BIT];
  wire [2:0] ratio      = option_q[OPT_RATIO_LSB +: 3];
  wire       wdt_clear  = watchdog_clear_instr || sleep_instr;
  wire       ps_clear   = (wr_timer && !assign_wdt) ||
                          (wdt_clear && assign_wdt);
  wire       timer_inc;
  wire       wdt_step;
  wire       wdt_timeout = wdt_step && !wdt_clear &&
                           (wdt_cnt_q == WDT_W'(WDT_LIMIT - 1));

  rci_prescaler #(
    .CNT_W      (8)
  ) u_prescaler (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .assign_wdt (assign_wdt),
    .ratio      (ratio),
    .clear      (ps_clear),
    .timer_src  (timer_tick),
    .wdt_src    (wdt_osc_tick),
    .timer_inc  (timer_inc),
    .wdt_step   (wdt_step)
  );

  // ----------------------------------------------------------------------
  // event resolution, highest first
  // ----------------------------------------------------------------------
  wire       bor_hit  = brown_out_evt && cfg_q[CFG_BOD_EN_BIT];
  wire       wake_hit = sleep_q && (int_wake_evt || cmp_wake_evt);
  rci_cond_t cond;
  assign cond = bor_hit                    ? cond_brown_out :
                (ext_reset_evt && sleep_q) ? cond_ext_sleep :
                ext_reset_evt              ? cond_ext_run :
                (wdt_timeout && sleep_q)   ? cond_wdt_wake :
                wdt_timeout                ? cond_wdt_reset :
                wake_hit                   ? cond_int_wake : cond_none;
  wire       is_reset = (cond == cond_brown_out) || (cond == cond_ext_run) ||
                        (cond == cond_ext_sleep) || (cond == cond_wdt_reset);
  wire       is_wake  = (cond == cond_wdt_wake) || (cond == cond_int_wake);

  // status value loaded for each condition, unchanged bits kept from the current value
  function automatic logic [7:0] status_for(input rci_cond_t c,
                                            input logic [7:0] cur);
    case (c)
      cond_brown_out: status_for = {3'h0, 2'h3, cur[2:0]};
      cond_ext_run:   status_for = {3'h0, cur[4:0]};
      cond_ext_sleep: status_for = {3'h0, 2'h2, cur[2:0]};
      cond_wdt_reset: status_for = {4'h0, cur[3:0]};
      cond_wdt_wake:  status_for = {cur[7:5], 2'h0, cur[2:0]};
      cond_int_wake:  status_for = {cur[7:5], 2'h2, cur[2:0]};
      default:        status_for = cur;
    endcase
  endfunction : status_for

  wire [7:0] status_sw = (status_q & ~STATUS_SW_MASK) | (wdata_q & STATUS_SW_MASK);
  wire [7:0] status_d  = status_for(cond, wr_status ? status_sw : status_q);
  wire [7:0] cause_sw  = wr_cause ? (wdata_q & CAUSE_MASK) : cause_q;
  wire [7:0] cause_d   = bor_hit ? (cause_sw & ~(8'h01 << CAUSE_BOR_BIT))
                                 : cause_sw;
  wire [7:0] pir_sw    = wr_pir ? (wdata_q & PIR_MASK) : pir_q;
  wire       cmp_set   = (cond == cond_int_wake) && cmp_wake_evt;
  wire [7:0] pir_d     = cmp_set ? (pir_sw | (8'h01 << PIR_CMP_BIT)) : pir_sw;
  wire [1:0] osc_sel   = cfg_q[CFG_OSC_LSB +: 2];

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= wdata[7:0];
        wstrb0_q <= wstrb[0];
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // reset cause, status and flag registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q  <= CAUSE_RST;
      status_q <= STATUS_RST;
      pir_q    <= PIR_RST;
    end else if (ce) begin
      cause_q  <= cause_d;
      status_q <= status_d;
      pir_q    <= pir_d;
    end
  end

  // ----------------------------------------------------------------------
  // option, port b direction and config
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_q <= OPTION_RST;
      port_b_direction_q  <= PORT_B_DIR_RST;
      cfg_q    <= CFG_INIT & CFG_MASK;
    end else if (ce) begin
      if (is_reset) begin
        option_q <= OPTION_RST;
        port_b_direction_q  <= PORT_B_DIR_RST;
      end else begin
        if (wr_option) option_q <= wdata_q;
        if (wr_port_b_direction)  port_b_direction_q  <= wdata_q;
      end
      if (wr_cfg) cfg_q <= wdata_q & CFG_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator mode and external clock acceptance
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_mode_q     <= resistor_capacitor_mode;
      ext_clock_ok_q <= 1'b0;
    end else if (ce) begin
      osc_mode_q     <= rci_osc_mode_t'(osc_sel);
      ext_clock_ok_q <= (rci_osc_mode_t'(osc_sel) != resistor_capacitor_mode);
    end
  end

  // ----------------------------------------------------------------------
  // timer count and watchdog counter
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_q <= 8'h00;
      wdt_cnt_q     <= '0;
    end else if (ce) begin
      if (wr_timer) begin
        timer_count_q <= wdata_q;
      end else if (timer_inc) begin
        timer_count_q <= timer_count_q + 8'h01;
      end
      if (wdt_clear || is_reset || is_wake) begin
        wdt_cnt_q <= '0;
      end else if (wdt_step) begin
        wdt_cnt_q <= wdt_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sleep state and program counter loading
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_q      <= 1'b0;
      core_reset_q <= 1'b1;
      pc_load_q    <= 1'b1;
      pc_value_q   <= PC_RESET_ADDR;
      pc_state_q   <= pc_idle;
    end else if (ce) begin
      core_reset_q <= is_reset;
      pc_load_q    <= 1'b0;
      if (is_reset || is_wake) begin
        sleep_q <= 1'b0;
      end else if (sleep_instr) begin
        sleep_q <= 1'b1;
      end
      case (pc_state_q)
        pc_idle: begin
          if (is_reset) begin
            pc_load_q  <= 1'b1;
            pc_value_q <= PC_RESET_ADDR;
          end else if (is_wake) begin
            pc_load_q  <= 1'b1;
            pc_value_q <= pc_current + 13'h001;
            if (cond == cond_int_wake && global_interrupt_enable) begin
              pc_state_q <= pc_vector;
            end
          end
        end
        pc_vector: begin
          pc_load_q  <= 1'b1;
          pc_value_q <= is_reset ? PC_RESET_ADDR : PC_INT_VECTOR;
          pc_state_q <= pc_idle;
        end
        default: pc_state_q <= pc_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign awready          = awready_q;
  assign wready           = wready_q;
  assign bvalid           = bvalid_q;
  assign bresp            = bresp_q;
  assign arready          = arready_q;
  assign rvalid           = rvalid_q;
  assign rdata            = rdata_q;
  assign rresp            = rresp_q;
  assign core_reset       = core_reset_q;
  assign pc_load          = pc_load_q;
  assign pc_value         = pc_value_q;
  assign sleeping         = sleep_q;
  assign option_value     = option_q;
  assign port_b_direction = port_b_direction_q;
  assign osc_mode         = osc_mode_q;
  assign ext_clock_ok     = ext_clock_ok_q;

endmodule : rci_top

// ### rci_top_checker.sv
// rci_top_checker: port-level timing checks of the reset and init block
// assumes: bound into rci_top, single aclk domain
`timescale 1ns/1ps
module rci_top_checker
  import rci_pkg::*;
(
  // watched ports
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        brown_out_evt,
  input wire logic        ext_reset_evt,
  input wire logic        int_wake_evt,
  input wire logic        cmp_wake_evt,
  input wire logic        global_interrupt_enable,
  input wire logic [12:0] pc_current,
  input wire logic        core_reset,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        sleeping,
  input wire logic [7:0]  option_value,
  input wire logic [7:0]  port_b_direction,
  input wire logic [1:0]  osc_mode,
  input wire logic        ext_clock_ok
);
  // --------------------------------------------------------------
  // wake qualifier and assertions
  // --------------------------------------------------------------
  wire wk = ce && sleeping && !brown_out_evt && !ext_reset_evt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_EXT_PC: assert property (ce && ext_reset_evt |=>
    core_reset && pc_load && pc_value == 13'h0)
    else $error("pin reset did not load pc zero");
  AST_RST_ONCE: assert property (ce && ext_reset_evt ##1
    ce && !ext_reset_evt && !brown_out_evt |=> !core_reset && !pc_load)
    else $error("reset pulse longer than one cycle");
  AST_EXT_DIR: assert property (ce && ext_reset_evt |=>
    option_value == 8'hff && port_b_direction == 8'hff)
    else $error("reset left option or direction unset");
  AST_INT_VEC: assert property (wk && int_wake_evt && global_interrupt_enable |=>
    pc_load && pc_value == $past(pc_current) + 13'h1 ##1 pc_load && pc_value == 13'h004)
    else $error("interrupt wake did not vector");
  AST_WAKE_NOVEC: assert property (wk && int_wake_evt && !global_interrupt_enable
    |=> pc_load ##1 !pc_load)
    else $error("wake with enable clear vectored");
  AST_CMP_PC: assert property (wk && cmp_wake_evt |=>
    pc_load && !core_reset && !sleeping && pc_value == $past(pc_current) + 13'h1)
    else $error("comparator wake pc not next");
  AST_WAKE_KEEP: assert property (wk && (cmp_wake_evt || int_wake_evt) |=>
    $stable(option_value) && $stable(port_b_direction))
    else $error("wake changed option or direction");
  AST_CLK_OK: assert property (ext_clock_ok == (osc_mode != 2'h3))
    else $error("external clock flag wrong for mode");
endmodule : rci_top_checker

bind rci_top rci_top_checker rci_top_checker_i (.aclk, .aresetn, .ce, .brown_out_evt,
  .ext_reset_evt, .int_wake_evt, .cmp_wake_evt, .global_interrupt_enable, .pc_current,
  .core_reset, .pc_load, .pc_value, .sleeping, .option_value, .port_b_direction, .osc_mode,
  .ext_clock_ok);

// ### rci_top_test.sv
// rci_top_test: register-bus sequences with expected values
// assumes: rci_top built with a watchdog limit of 4 steps
`timescale 1ns/1ps
module rci_top_test
  import rci_pkg::*;
;
  // --------------------------------------------------------------
  // stimulus, wiring and bus tasks
  // --------------------------------------------------------------
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ta, tw, tb, global_interrupt_enable = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [7:0]  ev = 0; // brown, pin, int, cmp, wdclr, sleep, timer, wdt
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp, osc_mode;
  wire [31:0]  rdata;
  int          err_count = 0, compares = 0, n;
  always #4 aclk = ~aclk;
  rci_top #(.WDT_LIMIT(4)) rci_top_i (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .brown_out_evt(ev[7]), .ext_reset_evt(ev[6]),
    .int_wake_evt(ev[5]), .cmp_wake_evt(ev[4]), .global_interrupt_enable,
    .watchdog_clear_instr(ev[3]), .sleep_instr(ev[2]), .pc_current(13'h0100),
    .timer_tick(ev[1]), .wdt_osc_tick(ev[0]), .core_reset(), .pc_load(), .pc_value(),
    .sleeping(), .option_value(), .port_b_direction(), .osc_mode, .ext_clock_ok());
  task automatic report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait step
  task automatic guard;
    n++;
    if (n > 60) begin
      err_count++;
      report_and_stop;
    end
  endtask : guard
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
    n = 0;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      {ta, tw, tb} = {awready && awvalid, wready && wvalid, bvalid};
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      guard;
    end
    bready <= 0;
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0] er = 2'h0);
    logic [33:0] d;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    n = 0;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      {ta, tb, d} = {arready && arvalid, rvalid, rresp, rdata};
      @(posedge aclk);
      if (ta) arvalid <= 0;
      guard;
    end
    rready <= 0;
    chk(nm, {24'h0, e}, d[31:0]);
    chk("resp", {30'h0, er}, {30'h0, d[33:32]});
  endtask : rd
  // one-cycle event pulse, then settle
  task automatic pulse(input logic [7:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 8'h0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("osc_mode", 32'h3, {30'h0, osc_mode});
    rd("cause", 12'h238, 8'h00);
    rd("status", 12'h00c, 8'h18);
    wr(12'h238, 8'hff);
    rd("cause", 12'h238, 8'h03);
    rd("unmapped", 12'h3fc, 8'h00, 2'h2);
    wr(12'h00c, 8'hff);
    wr(12'h204, 8'h00);
    wr(12'h218, 8'h00);
    pulse(8'h40);
    rd("option", 12'h204, 8'hff);
    rd("status", 12'h00c, 8'h1f);
    rd("cause", 12'h238, 8'h03);
    pulse(8'h80);
    rd("cause", 12'h238, 8'h02);
    rd("status", 12'h00c, 8'h1f);
    for (int m = 0; m < 4; m++) begin
      wr(12'h240, 8'h40 | m[7:0]);
      @(negedge aclk);
      chk("osc_mode", m, {30'h0, osc_mode});
    end
    pulse(8'h04);
    global_interrupt_enable <= 1;
    pulse(8'h20);
    rd("status", 12'h00c, 8'h17);
    global_interrupt_enable <= 0;
    pulse(8'h04);
    pulse(8'h30);
    rd("pir", 12'h030, 8'h40);
    wr(12'h204, 8'h00);
    pulse(8'h02);
    pulse(8'h02);
    wr(12'h004, 8'h00);
    pulse(8'h02);
    wr(12'h004, 8'h00);
    pulse(8'h02);
    rd("timer", 12'h004, 8'h00);
    pulse(8'h02);
    rd("timer", 12'h004, 8'h01);
    pulse(8'h08);
    n = 0;
    while (rci_top_i.option_value !== 8'hff) begin
      pulse(8'h01);
      guard;
    end
    rd("status", 12'h00c, 8'h07);
    // second power-on in mid-run
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd("cause", 12'h238, 8'h00);
    rd("status", 12'h00c, 8'h18);
    report_and_stop;
  end
endmodule : rci_top_test
